// ### verilog/gpio_port_pkg.sv
// Package with register map, field layout and carrier types of the shared-pin I/O port
package gpio_port_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned PORT_W = 8;

  // Register addresses in the data space
  localparam logic [15:0] PIN_FUNCTION_SELECT_ADDR   = 16'h7090;
  localparam logic [15:0] PORT_A_DATA_DIRECTION_ADDR = 16'h7098;
  localparam logic [15:0] PORT_B_DATA_DIRECTION_ADDR = 16'h709a;

  // Field positions
  localparam int unsigned SEL_PORT_A_LSB = 0;
  localparam int unsigned SEL_PORT_B_LSB = 8;
  localparam int unsigned DAT_LSB        = 0;
  localparam int unsigned DIR_LSB        = 8;

  // Pin positions with extra input taps
  localparam int unsigned FAULT_PIN    = 0;
  localparam int unsigned PA_EVENT_PIN = 7;
  localparam int unsigned PB_EVENT_PIN = 0;

  // Reset values
  localparam logic [15:0] PIN_FUNCTION_SELECT_RST = 16'h0000;
  localparam logic [7:0]  PORT_DATA_RST           = 8'h00;
  localparam logic [7:0]  PORT_DIR_RST            = 8'h00;
  localparam logic [15:0] READ_DATA_RST           = 16'h0000;
  localparam logic [7:0]  PAD_RELEASED_RST        = 8'hff;

  // Peripheral bus request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } bus_req_t;

  // One 8-bit port of pad signals
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
  } pad_drive_t;

  // Input events taken off the pins for other peripherals
  typedef struct packed {
    logic power_drive_protect_input;
    logic external_interrupt_one;
    logic external_interrupt_two;
    logic converter_start_trigger;
    logic capture_input;
  } pin_taps_t;

endpackage

// ### verilog/gpio_pin_slice.sv
// One 8-bit port: mux between peripheral function and I/O, output enable generation
`timescale 1ns/1ns
`default_nettype none
module gpio_pin_slice
  import gpio_port_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] i_select,
  input  wire logic [WIDTH-1:0] i_io_data,
  input  wire logic [WIDTH-1:0] i_io_dir,
  input  wire logic [WIDTH-1:0] i_func_out,
  input  wire logic [WIDTH-1:0] i_func_oe,
  output logic      [WIDTH-1:0] o_out,
  output logic      [WIDTH-1:0] o_oe_n
);

  // Select 1 gives the pin to its peripheral, 0 to the I/O logic
  // Direction 1 drives, 0 leaves the driver off
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      o_out[i]  = i_select[i] ? i_func_out[i] : i_io_data[i];
      o_oe_n[i] = i_select[i] ? ~i_func_oe[i] : ~i_io_dir[i];
    end
  end

endmodule
`default_nettype wire

// ### verilog/shared_pin_gpio_port.sv
// Shared-pin general-purpose I/O port with two 8-bit ports and function select
`timescale 1ns/1ns
`default_nettype none
module shared_pin_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned PORTS_W = PORT_W
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_sys_rst,
  input  wire bus_req_t           i_bus,
  output logic      [DATA_W-1:0]  o_bus_rdata,
  output logic                    o_bus_rvalid,
  input  wire logic [PORTS_W-1:0] i_port_a_pin,
  input  wire logic [PORTS_W-1:0] i_port_b_pin,
  input  wire logic [PORTS_W-1:0] i_port_a_func_out,
  input  wire logic [PORTS_W-1:0] i_port_a_func_oe,
  input  wire logic [PORTS_W-1:0] i_port_b_func_out,
  input  wire logic [PORTS_W-1:0] i_port_b_func_oe,
  output pad_drive_t              o_port_a_pad,
  output pad_drive_t              o_port_b_pad,
  output logic      [PORTS_W-1:0] o_port_a_func_in,
  output logic      [PORTS_W-1:0] o_port_b_func_in,
  output pin_taps_t               o_taps
);

  // Whole state of the block
  typedef struct packed {
    logic [15:0] select;
    logic [7:0]  a_data;
    logic [7:0]  a_dir;
    logic [7:0]  b_data;
    logic [7:0]  b_dir;
    logic [7:0]  a_sample;
    logic [7:0]  b_sample;
    logic [15:0] rdata;
    logic        rvalid;
    pad_drive_t  a_pad;
    pad_drive_t  b_pad;
    logic [7:0]  a_func_in;
    logic [7:0]  b_func_in;
    pin_taps_t   taps;
  } state_t;

  // Register hit by the bus address; anything unmapped hits none
  typedef enum logic [1:0] {
    reg_none,
    reg_select,
    reg_port_a,
    reg_port_b
  } reg_sel_t;

  state_t     st;
  state_t     next_st;
  pad_drive_t a_pad_comb;
  pad_drive_t b_pad_comb;
  reg_sel_t   bus_target;
  logic [7:0] a_select;
  logic [7:0] b_select;

  // Read value of a port: inputs show the pin, outputs the latch
  function automatic logic [15:0] port_word(input logic [7:0] data, input logic [7:0] dir,
                                            input logic [7:0] pin);
    logic [7:0] shown;
    shown = (dir & data) | (~dir & pin);
    return {dir, shown};
  endfunction

  // Write of a port register: data low byte, direction high byte
  function automatic logic [15:0] port_write(input logic [15:0] w);
    return {w[DIR_LSB +: PORT_W], w[DAT_LSB +: PORT_W]};
  endfunction

  // One address decoder shared by reads and writes, so both always agree
  function automatic reg_sel_t decode_addr(input logic [15:0] addr);
    reg_sel_t hit;
    unique case (addr)
      PIN_FUNCTION_SELECT_ADDR:   hit = reg_select;
      PORT_A_DATA_DIRECTION_ADDR: hit = reg_port_a;
      PORT_B_DATA_DIRECTION_ADDR: hit = reg_port_b;
      default:                    hit = reg_none;
    endcase
    return hit;
  endfunction

  // Peripheral inputs see the pin only where the function owns it
  function automatic logic [7:0] to_peripheral(input logic [7:0] sample,
                                               input logic [7:0] select);
    return sample & select;
  endfunction

  // Event taps see the pin only while it is a plain I/O pin
  function automatic logic io_tap(input logic level, input logic select_bit);
    return level & ~select_bit;
  endfunction

  // Port A pin mux
  gpio_pin_slice #(
    .WIDTH (PORT_W)
  ) u_slice_a (
    .i_select   (a_select),
    .i_io_data  (st.a_data),
    .i_io_dir   (st.a_dir),
    .i_func_out (i_port_a_func_out),
    .i_func_oe  (i_port_a_func_oe),
    .o_out      (a_pad_comb.out),
    .o_oe_n     (a_pad_comb.oe_n)
  );

  // Port B pin mux
  gpio_pin_slice #(
    .WIDTH (PORT_W)
  ) u_slice_b (
    .i_select   (b_select),
    .i_io_data  (st.b_data),
    .i_io_dir   (st.b_dir),
    .i_func_out (i_port_b_func_out),
    .i_func_oe  (i_port_b_func_oe),
    .o_out      (b_pad_comb.out),
    .o_oe_n     (b_pad_comb.oe_n)
  );

  // Address decoded once and shared by both strobes
  assign bus_target = decode_addr(i_bus.addr);
  // Select halves of the two ports
  assign a_select   = st.select[SEL_PORT_A_LSB +: PORT_W];
  assign b_select   = st.select[SEL_PORT_B_LSB +: PORT_W];

  // Next-state logic: bus writes, reads, pin sampling and taps
  always_comb begin
    next_st = st;
    // Pins sampled once so a read and the taps agree on the same level
    next_st.a_sample = i_port_a_pin;
    next_st.b_sample = i_port_b_pin;

    // All registers are full 16-bit words on the peripheral bus
    // A write and a read in one cycle both act; the read sees the old value
    if (i_bus.wr) begin
      unique case (bus_target)
        reg_select: next_st.select = i_bus.wdata;
        reg_port_a: {next_st.a_dir, next_st.a_data} = port_write(i_bus.wdata);
        reg_port_b: {next_st.b_dir, next_st.b_data} = port_write(i_bus.wdata);
        reg_none:   ; // Unmapped writes are ignored
      endcase
    end

    // Read answer one cycle after the strobe; unmapped reads give zero
    // Unmapped reads still answer, so a stray address never hangs the bus
    next_st.rvalid = i_bus.rd;
    next_st.rdata  = READ_DATA_RST;
    if (i_bus.rd) begin
      unique case (bus_target)
        reg_select: next_st.rdata = st.select;
        reg_port_a: next_st.rdata = port_word(st.a_data, st.a_dir, st.a_sample);
        reg_port_b: next_st.rdata = port_word(st.b_data, st.b_dir, st.b_sample);
        reg_none:   next_st.rdata = READ_DATA_RST;
      endcase
    end

    // Pad drive registered so every output comes from a flip-flop
    next_st.a_pad = a_pad_comb;
    next_st.b_pad = b_pad_comb;

    // Peripheral inputs only see the pin while the function is selected
    next_st.a_func_in = to_peripheral(st.a_sample, a_select);
    next_st.b_func_in = to_peripheral(st.b_sample, b_select);

    // Fault input is never gated by the select bit
    next_st.taps.power_drive_protect_input = st.a_sample[FAULT_PIN];
    // Event inputs come from the pins while they are in I/O mode
    next_st.taps.external_interrupt_two  = io_tap(st.a_sample[PA_EVENT_PIN],
                                                  a_select[PA_EVENT_PIN]);
    next_st.taps.converter_start_trigger = next_st.taps.external_interrupt_two;
    next_st.taps.capture_input           = next_st.taps.external_interrupt_two;
    next_st.taps.external_interrupt_one  = io_tap(st.b_sample[PB_EVENT_PIN],
                                                  b_select[PB_EVENT_PIN]);
  end

  // State register; reset leaves every pin an undriven I/O input
  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      // Every field named, so no state hides behind a blanket clear
      st.select      <= PIN_FUNCTION_SELECT_RST;
      st.a_data      <= PORT_DATA_RST;
      st.a_dir       <= PORT_DIR_RST;
      st.b_data      <= PORT_DATA_RST;
      st.b_dir       <= PORT_DIR_RST;
      st.a_sample    <= PORT_DATA_RST;
      st.b_sample    <= PORT_DATA_RST;
      st.rdata       <= READ_DATA_RST;
      st.rvalid      <= '0;
      st.a_pad.out   <= PORT_DATA_RST;
      st.a_pad.oe_n  <= PAD_RELEASED_RST;
      st.b_pad.out   <= PORT_DATA_RST;
      st.b_pad.oe_n  <= PAD_RELEASED_RST;
      st.a_func_in   <= PORT_DATA_RST;
      st.b_func_in   <= PORT_DATA_RST;
      st.taps        <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flip-flops
  assign o_bus_rdata      = st.rdata;
  assign o_bus_rvalid     = st.rvalid;
  assign o_port_a_pad     = st.a_pad;
  assign o_port_b_pad     = st.b_pad;
  assign o_port_a_func_in = st.a_func_in;
  assign o_port_b_func_in = st.b_func_in;
  assign o_taps           = st.taps;

endmodule
`default_nettype wire

// ### verification/gpio_port_monitor.sv
// Checker of bus answers, pin taps and port A peripheral inputs of the I/O port
`timescale 1ns/1ns
`default_nettype none
module gpio_port_monitor
  import gpio_port_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_sys_rst,
  input wire bus_req_t    i_bus,
  input wire logic [15:0] o_bus_rdata,
  input wire logic        o_bus_rvalid,
  input wire logic [7:0]  i_port_a_pin,
  input wire logic [7:0]  i_port_b_pin,
  input wire logic [7:0]  o_port_a_func_in,
  input wire pin_taps_t   o_taps
);
  // One clock domain, so checks share clock and reset
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  read_answer_a: assert property (i_bus.rd |=> o_bus_rvalid)
    else $error("read not answered");
  valid_pulse_a: assert property (!i_bus.rd |=> !o_bus_rvalid)
    else $error("answer without read");
  select_readback_a: assert property (i_bus.wr && i_bus.addr == 16'h7090 ##1
    i_bus.rd && !i_bus.wr && i_bus.addr == 16'h7090 |=> o_bus_rdata == $past(i_bus.wdata, 2))
    else $error("select readback differs");
  unmapped_read_a: assert property (i_bus.rd && !i_bus.wr &&
    !(i_bus.addr inside {16'h7090, 16'h7098, 16'h709a}) |=> o_bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  fault_tap_a: assert property (1 |-> ##2
    o_taps.power_drive_protect_input == $past(i_port_a_pin[0], 2))
    else $error("fault tap lost pin");
  event_two_a: assert property (o_taps.external_interrupt_two |-> $past(i_port_a_pin[7], 2))
    else $error("tap two without pin");
  event_one_a: assert property (o_taps.external_interrupt_one |-> $past(i_port_b_pin[0], 2))
    else $error("tap one without pin");
  func_in_a: assert property ((o_port_a_func_in & ~$past(i_port_a_pin, 2)) == 8'h00)
    else $error("peripheral input without pin");
endmodule
`default_nettype wire

// ### verification/pin_partner.sv
// Far side of the pins: each pad resolves between port driver and outside level
`timescale 1ns/1ns
`default_nettype none
module pin_partner
  import gpio_port_pkg::*;
(
  input  wire pad_drive_t i_a_pad,
  input  wire pad_drive_t i_b_pad,
  input  wire logic [7:0] i_a_ext,
  input  wire logic [7:0] i_b_ext,
  output logic      [7:0] o_a_pin,
  output logic      [7:0] o_b_pin
);
  // Driven bits follow the port, released bits take the outside level
  assign o_a_pin = (i_a_pad.out & ~i_a_pad.oe_n) | (i_a_ext & i_a_pad.oe_n);
  assign o_b_pin = (i_b_pad.out & ~i_b_pad.oe_n) | (i_b_ext & i_b_pad.oe_n);
endmodule
`default_nettype wire

// ### verification/shared_pin_gpio_port_tb.sv
// Self-checking bench of the shared-pin I/O port
`timescale 1ns/1ns
`default_nettype none
module shared_pin_gpio_port_tb
  import gpio_port_pkg::*;
();
  logic       i_sys_clk, i_sys_rst, o_bus_rvalid;
  bus_req_t   i_bus;
  logic [15:0] o_bus_rdata;
  logic [7:0] a_ext, b_ext, i_port_a_pin, i_port_b_pin, o_port_a_func_in, o_port_b_func_in;
  logic [7:0] i_port_a_func_out, i_port_a_func_oe, i_port_b_func_out, i_port_b_func_oe;
  pad_drive_t o_port_a_pad, o_port_b_pad;
  pin_taps_t  o_taps;
  int         failures, comparisons;
  pin_partner partner (.i_a_pad(o_port_a_pad), .i_b_pad(o_port_b_pad), .i_a_ext(a_ext),
    .i_b_ext(b_ext), .o_a_pin(i_port_a_pin), .o_b_pin(i_port_b_pin));
  shared_pin_gpio_port dut (.i_sys_clk, .i_sys_rst, .i_bus, .o_bus_rdata, .o_bus_rvalid,
    .i_port_a_pin, .i_port_b_pin, .i_port_a_func_out, .i_port_a_func_oe, .i_port_b_func_out,
    .i_port_b_func_oe, .o_port_a_pad, .o_port_b_pad, .o_port_a_func_in, .o_port_b_func_in,
    .o_taps);
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes held across exactly one rising edge
  task automatic wr(input logic [15:0] addr, input logic [15:0] data);
    @(negedge i_sys_clk);
    i_bus = {1'h0, 1'h1, addr, data};
    @(negedge i_sys_clk);
    i_bus.wr = 1'h0;
  endtask
  task automatic rd(input logic [15:0] addr, input logic [15:0] exp, input string what);
    @(negedge i_sys_clk);
    i_bus = {1'h1, 1'h0, addr, 16'h0000};
    @(negedge i_sys_clk);
    i_bus.rd = 1'h0;
    chk(what, o_bus_rdata, exp);
    chk("read valid", {15'h0000, o_bus_rvalid}, 16'h0001);
  endtask
  task automatic t_reset_inputs;
    chk("pad A enables", {8'h00, o_port_a_pad.oe_n}, 16'h00ff);
    rd(PIN_FUNCTION_SELECT_ADDR, 16'h0000, "select");
    rd(PORT_A_DATA_DIRECTION_ADDR, 16'h0081, "port A");
    chk("taps", {11'h000, o_taps}, 16'h001f);
  endtask
  task automatic t_outputs;
    b_ext = 8'hc3;
    wr(PORT_A_DATA_DIRECTION_ADDR, 16'hff3d);
    wr(PORT_B_DATA_DIRECTION_ADDR, 16'h0fa5);
    repeat (2) @(negedge i_sys_clk);
    chk("pad A", o_port_a_pad, 16'h3d00);
    chk("pad B", {o_port_b_pad.out & 8'h0f, o_port_b_pad.oe_n}, 16'h05f0);
    rd(PORT_B_DATA_DIRECTION_ADDR, 16'h0fc5, "port B");
  endtask
  task automatic t_select;
    wr(PIN_FUNCTION_SELECT_ADDR, 16'h0180);
    rd(16'h7092, 16'h0000, "unmapped");
    rd(PIN_FUNCTION_SELECT_ADDR, 16'h0180, "select");
    chk("func pads", {13'h0000, o_port_a_pad.out[7], o_port_a_pad.oe_n[7],
      o_port_b_pad.oe_n[0]}, 16'h0004);
    chk("func in A", {8'h00, o_port_a_func_in}, 16'h0080);
    chk("taps gated", {11'h000, o_taps}, 16'h0010);
    chk("func in B", {8'h00, o_port_b_func_in}, 16'h0001);
  endtask
  // Write then read of the select register on consecutive edges
  task automatic t_back_to_back;
    @(negedge i_sys_clk);
    i_bus = {1'h0, 1'h1, PIN_FUNCTION_SELECT_ADDR, 16'h8001};
    @(negedge i_sys_clk);
    i_bus = {1'h1, 1'h0, PIN_FUNCTION_SELECT_ADDR, 16'h0000};
    @(negedge i_sys_clk);
    i_bus.rd = 1'h0;
    chk("select back to back", o_bus_rdata, 16'h8001);
  endtask
  // Reset in mid-run must release the pads and clear every select bit
  task automatic t_mid_reset;
    @(negedge i_sys_clk);
    i_sys_rst = 1'h1;
    repeat (2) @(negedge i_sys_clk);
    chk("pads held", {o_port_a_pad.oe_n, o_port_b_pad.oe_n}, 16'hffff);
    i_sys_rst = 1'h0;
    rd(PIN_FUNCTION_SELECT_ADDR, 16'h0000, "select after reset");
    chk("func in reset", {o_port_a_func_in, o_port_b_func_in}, 16'h0000);
  endtask
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'h0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  // Scenarios need under 60 cycles, so 1000 means a hang
  initial begin
    repeat (1000) @(posedge i_sys_clk);
    failures++;
    conclude();
  end
  initial begin
    i_sys_rst = 1'h1;
    i_bus = '0;
    a_ext = 8'h81;
    b_ext = 8'h01;
    i_port_a_func_out = 8'h80;
    i_port_a_func_oe = 8'h80;
    i_port_b_func_out = 8'h01;
    i_port_b_func_oe = 8'h01;
    repeat (8) @(negedge i_sys_clk);
    i_sys_rst = 1'h0;
    repeat (3) @(negedge i_sys_clk);
    t_reset_inputs();
    t_outputs();
    t_select();
    t_back_to_back();
    t_mid_reset();
    conclude();
  end
endmodule
bind shared_pin_gpio_port gpio_port_monitor mon (.i_sys_clk, .i_sys_rst, .i_bus,
  .o_bus_rdata, .o_bus_rvalid, .i_port_a_pin, .i_port_b_pin, .o_port_a_func_in, .o_taps);
`default_nettype wire
